// ---- common/ipr_defines.vh ----
// Constants for the cascaded legacy interrupt router: register offsets,
// field layouts, reset values and timer figures.
// Assumes inclusion by bare name from the design files under src/.
`ifndef IPR_DEFINES_VH
`define IPR_DEFINES_VH

// Register byte offsets on the APB (each register is one aligned word)
`define IPR_OFF_ELS        8'h00
`define IPR_OFF_MASK       8'h04
`define IPR_OFF_ROUTE      8'h08
`define IPR_OFF_IRR        8'h0c
`define IPR_OFF_ISR        8'h10
`define IPR_OFF_ACK        8'h14
`define IPR_OFF_EOI        8'h18
`define IPR_OFF_TIMER      8'h1c
`define IPR_OFF_EVT_STAT   8'h20
`define IPR_OFF_EVT_MASK   8'h24

// Reset values
`define IPR_ELS_RST        16'h0000
`define IPR_MASK_RST       16'hffff
`define IPR_ROUTE_RST      32'h80808080
`define IPR_TIMER_RST      16'hffff
`define IPR_EVT_MASK_RST   3'h0

// Lines whose sensing may be changed (0, 1, 8 and 13 stay edge, 2 stays level)
`define IPR_ELS_WMASK      16'hdef8
// Lines that a PCI interrupt may be steered to (twelve of them)
`define IPR_ROUTE_OK       16'hdefa
// Lines fed from pins (line 0 is the timer, line 2 the cascade)
`define IPR_PIN_LINES      16'hfffa
// Edge-mode lines that request on a falling edge instead of a rising one
`define IPR_EDGE_LOW       16'h0100

// Route byte layout
`define IPR_RT_DIS_BIT     7
`define IPR_RT_IRQ_W       4

// Acknowledge word layout
`define IPR_ACK_VALID_BIT  8
`define IPR_SPURIOUS_IRQ   4'h7

// Cascade position on the primary controller
`define IPR_CASCADE_IDX    3'h2

// Event bits
`define IPR_EV_INT         0
`define IPR_EV_SPUR        1
`define IPR_EV_TICK        2
`define IPR_EV_W           3

// Timer input prescale (system clock cycles per timer count)
`define IPR_TMR_PRESCALE   168

`endif

// ---- src/ipr_ctrl8.v ----
// One eight-input priority interrupt controller slice with request latch,
// in-service bits, acknowledge and non-specific end of interrupt.
// Assumes requests are already synchronous to clk and active high.
`timescale 1ns/10ps
module ipr_ctrl8 (
    input  wire       clk,       // System clock
    input  wire       rst,       // Asynchronous reset, active high
    input  wire [7:0] req,       // Request levels, active high
    input  wire [7:0] edge_mode, // 1 = edge sensing, 0 = level sensing
    input  wire [7:0] mask,      // 1 = request masked
    input  wire       ack,       // Acknowledge pulse
    input  wire [2:0] ack_idx,   // Line being acknowledged
    input  wire       eoi,       // Non-specific end of interrupt pulse
    output wire [7:0] irr,       // Request register view
    output reg  [7:0] isr,       // In-service register
    output reg        int_req,   // Unmasked request above all in service
    output reg  [2:0] top_idx    // Highest priority pending line
);

    reg  [7:0] req_prev;         // Last request levels, for edge detection
    reg  [7:0] edge_latch;       // Latched edges awaiting acknowledge
    reg  [7:0] next_isr;         // In-service after this cycle's events
    reg  [7:0] clr_latch;        // Latch bits cleared by acknowledge
    reg  [3:0] isr_top;          // Lowest index in service, 8 when none
    reg        found;            // Priority search flag
    reg        eoi_done;         // Only one bit cleared per end of interrupt
    integer    i;                // Loop index, priority search
    integer    j;                // Loop index, end of interrupt scan

    // Edges seen this cycle on edge-mode lines
    wire [7:0] edge_seen = req & ~req_prev & edge_mode;

    // Classic latch
    // edge latched, level followed
    assign irr = (edge_mode & edge_latch) | (~edge_mode & req);

    // Priority resolution: index 0 is the highest
    always @* begin
        isr_top = 4'h8;
        top_idx = 3'h0;
        found   = 1'b0;
        for (i = 7; i >= 0; i = i - 1) begin
            if (isr[i]) begin
                isr_top = i[3:0];
            end
        end
        for (i = 7; i >= 0; i = i - 1) begin
            if (irr[i] && !mask[i]) begin
                top_idx = i[2:0];
                found   = 1'b1;
            end
        end
        // A request only interrupts when above everything in service
        int_req = found && ({1'b0, top_idx} < isr_top);
    end

    // Next in-service and latch clear terms
    always @* begin
        next_isr  = isr;
        clr_latch = 8'h00;
        eoi_done  = 1'b0;
        if (eoi) begin
            for (j = 0; j < 8; j = j + 1) begin
                if (next_isr[j] && !eoi_done) begin
                    next_isr[j] = 1'b0;
                    eoi_done    = 1'b1;
                end
            end
        end
        if (ack) begin
            next_isr[ack_idx]  = 1'b1;
            clr_latch[ack_idx] = 1'b1;
        end
    end

    // State update; a fresh edge in the acknowledge cycle is kept
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            req_prev   <= 8'h00;
            edge_latch <= 8'h00;
            isr        <= 8'h00;
        end else begin
            req_prev   <= req;
            edge_latch <= ((edge_latch & ~clr_latch) | edge_seen) & edge_mode;
            isr        <= next_isr;
        end
    end

endmodule

// ---- src/ipr_top.v ----
// Cascaded pair of legacy interrupt controllers with PCI interrupt
// steering, an internal timer on line 0 and an APB register slave.
// Assumes ISA and PCI pins are asynchronous to MCLK; APB runs on MCLK.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "ipr_defines.vh"

module ipr_top #(
    parameter PRESCALE = `IPR_TMR_PRESCALE     // Clock cycles per timer count
) (
    input  wire        MCLK,                   // System clock, 200 MHz
    input  wire        SYS_RST,                // Asynchronous reset, active high
    input  wire [15:0] IRQ_IN,                 // ISA request pins
    input  wire [3:0]  PCI_INT_N,              // pci_int_line_a..d, active low
    input  wire        PSEL,                   // APB select
    input  wire        PENABLE,                // APB access phase
    input  wire        PWRITE,                 // APB direction
    input  wire [7:0]  PADDR,                  // APB byte address
    input  wire [31:0] PWDATA,                 // APB write data
    output reg         PREADY,                 // APB ready
    output reg  [31:0] PRDATA,                 // APB read data
    output reg         PSLVERR,                // APB error on unmapped address
    output reg         INT_OUT,                // Cascade output to the processor
    output reg         EVT_IRQ                 // Event interrupt, level
);

    // Pin synchronisers
    reg  [15:0] isa_s1;                        // First stage, read only by isa_s2
    reg  [15:0] isa_s2;                        // Synchronised ISA pins
    reg  [3:0]  pci_s1;                        // First stage, read only by pci_s2
    reg  [3:0]  pci_s2;                        // Synchronised PCI pins

    // Software registers
    reg  [15:0] edge_level_select;             // 1 = level sensing
    reg  [15:0] irq_mask;                      // 1 = line masked
    reg  [31:0] route;                         // One byte per PCI line
    reg  [15:0] timer_reload;                  // Timer count reload
    reg  [`IPR_EV_W-1:0] evt_status;           // Sticky events
    reg  [`IPR_EV_W-1:0] evt_mask;             // 1 = event enabled

    // Timer state
    reg  [7:0]  pre_cnt;                       // Prescale divider
    reg  [15:0] tmr_cnt;                       // Timer counter
    reg         timer_out;                     // Square wave feeding line 0

    // Captured read state for side effects at completion
    reg  [2:0]  ack_p_idx;                     // Primary line to acknowledge
    reg  [2:0]  ack_s_idx;                     // Secondary line to acknowledge
    reg         ack_p_go;                      // Primary acknowledge pending
    reg         ack_s_go;                      // Secondary acknowledge pending
    reg  [`IPR_EV_W-1:0] evt_cap;              // Event bits returned by the read

    // Combinational helpers
    reg  [15:0] pci_hit;                       // Lines requested by PCI inputs
    reg  [31:0] rd_val;                        // Read mux
    reg         hit;                           // Address decoded
    reg  [`IPR_EV_W-1:0] ev_set;               // Events this cycle
    reg  [`IPR_EV_W-1:0] next_evt;             // Next event status
    integer     n;                             // Loop index
    integer     l;                             // Loop index

    // Controller outputs
    wire [7:0]  p_irr;                         // Primary request view
    wire [7:0]  p_isr;                         // Primary in service
    wire        p_int;                         // Primary interrupt
    wire [2:0]  p_top;                         // Primary top line
    wire [7:0]  s_irr;                         // Secondary request view
    wire [7:0]  s_isr;                         // Secondary in service
    wire        s_int;                         // Secondary interrupt into line 2
    wire [2:0]  s_top;                         // Secondary top line

    // Bus phases: capture in first access cycle, complete when ready seen
    wire acc  = PSEL & PENABLE;
    wire cap  = acc & ~PREADY;
    wire done = acc & PREADY;
    wire wr_done = done & PWRITE & hit;
    wire rd_ack  = done & ~PWRITE & (PADDR == `IPR_OFF_ACK);
    wire rd_evt  = done & ~PWRITE & (PADDR == `IPR_OFF_EVT_STAT);
    // A reload write restarts the count, else a long old count delays it
    wire tmr_load = wr_done & (PADDR == `IPR_OFF_TIMER);
    // Lines that a PCI input may reach, as an indexable vector
    wire [15:0] route_ok = `IPR_ROUTE_OK;

    wire [15:0] els_eff = edge_level_select & `IPR_ELS_WMASK;

    // Two-stage synchronisers on every pin input
    always @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            // Idle pin levels, so line 8 sees no false edge after reset
            isa_s1 <= `IPR_EDGE_LOW;
            isa_s2 <= `IPR_EDGE_LOW;
            pci_s1 <= 4'hf;
            pci_s2 <= 4'hf;
        end else begin
            isa_s1 <= IRQ_IN;
            isa_s2 <= isa_s1;
            pci_s1 <= PCI_INT_N;
            pci_s2 <= pci_s1;
        end
    end

    // PCI steering; a route to a reserved line is simply ignored
    always @* begin
        pci_hit = 16'h0000;
        for (n = 0; n < 4; n = n + 1) begin
            for (l = 0; l < 16; l = l + 1) begin
                if (!route[n*8+`IPR_RT_DIS_BIT] && !pci_s2[n] &&
                    route[n*8 +: `IPR_RT_IRQ_W] == l[3:0] && route_ok[l]) begin
                    pci_hit[l] = 1'b1;
                end
            end
        end
    end

    // Level lines request while low; edge lines on rising, line 8 on falling.
    // Routed PCI requests are levels, so software keeps those lines level; line 1 cannot be changed and stays edge.
    wire [15:0] isa_act  = (els_eff & ~isa_s2) | (~els_eff & (isa_s2 ^ `IPR_EDGE_LOW));
    wire [15:0] line_req = (isa_act & `IPR_PIN_LINES) | pci_hit;

    wire [7:0] p_req = {line_req[7:3], s_int, line_req[1], timer_out};

    ipr_ctrl8 u_primary (
        .clk       (MCLK),
        .rst       (SYS_RST),
        .req       (p_req),
        .edge_mode (~els_eff[7:0] & ~(8'h01 << `IPR_CASCADE_IDX)),
        .mask      (irq_mask[7:0]),
        .ack       (rd_ack & ack_p_go),
        .ack_idx   (ack_p_idx),
        .eoi       (wr_done & (PADDR == `IPR_OFF_EOI) & PWDATA[0]),
        .irr       (p_irr),
        .isr       (p_isr),
        .int_req   (p_int),
        .top_idx   (p_top)
    );

    ipr_ctrl8 u_secondary (
        .clk       (MCLK),
        .rst       (SYS_RST),
        .req       (line_req[15:8]),
        .edge_mode (~els_eff[15:8]),
        .mask      (irq_mask[15:8]),
        .ack       (rd_ack & ack_s_go),
        .ack_idx   (ack_s_idx),
        .eoi       (wr_done & (PADDR == `IPR_OFF_EOI) & PWDATA[1]),
        .irr       (s_irr),
        .isr       (s_isr),
        .int_req   (s_int),
        .top_idx   (s_top)
    );

    // Timer: prescaler enable, then a reloading counter toggling its output.
    // A reload of zero gives the longest period, as the counter wraps.
    always @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pre_cnt   <= 8'h00;
            tmr_cnt   <= `IPR_TIMER_RST;
            timer_out <= 1'b0;
        end else if (tmr_load) begin
            // New reload takes effect at once
            pre_cnt <= 8'h00;
            tmr_cnt <= PWDATA[15:0];
        end else if (pre_cnt == PRESCALE[7:0] - 8'h01) begin
            pre_cnt <= 8'h00;
            if (tmr_cnt == 16'h0001 || tmr_cnt == 16'h0000 && timer_reload == 16'h0001) begin
                tmr_cnt   <= timer_reload;
                timer_out <= ~timer_out;
            end else begin
                tmr_cnt <= tmr_cnt - 16'h0001;
            end
        end else begin
            pre_cnt <= pre_cnt + 8'h01;
        end
    end

    // Read mux and address decode
    always @* begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        case (PADDR)
            `IPR_OFF_ELS:      rd_val = {16'h0000, els_eff};
            `IPR_OFF_MASK:     rd_val = {16'h0000, irq_mask};
            `IPR_OFF_ROUTE:    rd_val = route;
            `IPR_OFF_IRR:      rd_val = {16'h0000, s_irr, p_irr};
            `IPR_OFF_ISR:      rd_val = {16'h0000, s_isr, p_isr};
            `IPR_OFF_ACK: begin
                if (p_int && p_top == `IPR_CASCADE_IDX && s_int) begin
                    rd_val = {23'h000000, 1'b1, 4'h0, 1'b1, s_top};
                end else if (p_int && p_top != `IPR_CASCADE_IDX) begin
                    rd_val = {23'h000000, 1'b1, 5'h00, p_top};
                end else begin
                    // Nothing to serve: spurious answer, valid bit clear
                    rd_val = {28'h0000000, `IPR_SPURIOUS_IRQ};
                end
            end
            `IPR_OFF_EOI:      rd_val = 32'h0000_0000;
            `IPR_OFF_TIMER:    rd_val = {16'h0000, timer_reload};
            `IPR_OFF_EVT_STAT: rd_val = {29'h00000000, evt_status};
            `IPR_OFF_EVT_MASK: rd_val = {29'h00000000, evt_mask};
            default:           hit = 1'b0;
        endcase
    end

    // APB answer: ready one cycle into the access phase, data registered
    always @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PREADY    <= 1'b0;
            PRDATA    <= 32'h0000_0000;
            PSLVERR   <= 1'b0;
            ack_p_go  <= 1'b0;
            ack_s_go  <= 1'b0;
            ack_p_idx <= 3'h0;
            ack_s_idx <= 3'h0;
            evt_cap   <= {`IPR_EV_W{1'b0}};
        end else begin
            PREADY <= cap;
            if (cap) begin
                PRDATA  <= PWRITE ? 32'h0000_0000 : rd_val;
                PSLVERR <= ~hit;
                // Freeze what the read returns so its side effect matches it
                ack_p_go  <= rd_val[`IPR_ACK_VALID_BIT];
                ack_s_go  <= rd_val[`IPR_ACK_VALID_BIT] & rd_val[3];
                ack_p_idx <= rd_val[3] ? `IPR_CASCADE_IDX : rd_val[2:0];
                ack_s_idx <= rd_val[2:0];
                evt_cap   <= evt_status;
            end else begin
                PSLVERR <= 1'b0;
            end
        end
    end

    // Software writes take effect at the completing edge
    always @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            edge_level_select <= `IPR_ELS_RST;
            irq_mask          <= `IPR_MASK_RST;
            route             <= `IPR_ROUTE_RST;
            timer_reload      <= `IPR_TIMER_RST;
            evt_mask          <= `IPR_EVT_MASK_RST;
        end else if (wr_done) begin
            case (PADDR)
                `IPR_OFF_ELS:      edge_level_select <= PWDATA[15:0] & `IPR_ELS_WMASK;
                `IPR_OFF_MASK:     irq_mask <= PWDATA[15:0];
                `IPR_OFF_ROUTE:    route <= PWDATA;
                `IPR_OFF_TIMER:    timer_reload <= PWDATA[15:0];
                `IPR_OFF_EVT_MASK: evt_mask <= PWDATA[`IPR_EV_W-1:0];
                default:           evt_mask <= evt_mask;
            endcase
        end
    end

    // Events: new interrupt, spurious acknowledge, timer rising edge
    always @* begin
        ev_set                = {`IPR_EV_W{1'b0}};
        ev_set[`IPR_EV_INT]   = p_int & ~INT_OUT;
        ev_set[`IPR_EV_SPUR]  = rd_ack & ~ack_p_go;
        ev_set[`IPR_EV_TICK]  = ~tmr_load & (pre_cnt == PRESCALE[7:0] - 8'h01) & ~timer_out &
                                (tmr_cnt == 16'h0001 || tmr_cnt == 16'h0000 &&
                                 timer_reload == 16'h0001);
        // A read clears only what it returned; a set in that cycle wins
        next_evt = (evt_status & ~(rd_evt ? evt_cap : {`IPR_EV_W{1'b0}})) | ev_set;
    end

    // Event status, level event output and cascade output
    always @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            evt_status <= {`IPR_EV_W{1'b0}};
            EVT_IRQ    <= 1'b0;
            INT_OUT    <= 1'b0;
        end else begin
            evt_status <= next_evt;
            EVT_IRQ    <= |(next_evt & evt_mask);
            INT_OUT    <= p_int;
        end
    end

endmodule

// ---- test/ipr_checker.sv ----
// Checker for the cascaded interrupt router, watching only top-level ports.
// Assumes one clock domain (MCLK) and the asynchronous active-high SYS_RST.
`timescale 1ns/10ps
`include "ipr_defines.vh"
module ipr_checker #(
    parameter int PRESCALE = `IPR_TMR_PRESCALE  // Mirrors the timer prescale of the top
) (
    input logic        MCLK,
    input logic        SYS_RST,
    input logic [15:0] IRQ_IN,
    input logic [3:0]  PCI_INT_N,
    input logic        PSEL,
    input logic        PENABLE,
    input logic        PWRITE,
    input logic [7:0]  PADDR,
    input logic [31:0] PWDATA,
    input logic        PREADY,
    input logic [31:0] PRDATA,
    input logic        PSLVERR,
    input logic        INT_OUT,
    input logic        EVT_IRQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    // Bus phases of one transfer
    sequence s_setup;  PSEL && !PENABLE; endsequence
    sequence s_access; PSEL && PENABLE; endsequence
    sequence s_done;   PSEL && PENABLE && PREADY; endsequence
    // Completed read of the acknowledge word
    sequence s_ack_rd; s_done ##0 (!PWRITE && PADDR == `IPR_OFF_ACK); endsequence

    property p_rdy_pulse;   PREADY |=> !PREADY; endproperty
    property p_wait_state;  s_setup ##1 s_access |-> !PREADY ##1 PREADY; endproperty
    property p_err_rdy;     PSLVERR |-> PREADY; endproperty
    property p_unmapped;
        s_done ##0 (PADDR > `IPR_OFF_EVT_MASK) |-> PSLVERR && PRDATA == 32'h0;
    endproperty
    property p_mapped;
        s_done ##0 (PADDR <= `IPR_OFF_EVT_MASK && PADDR[1:0] == 2'h0) |-> !PSLVERR;
    endproperty
    // Nothing pending answers with the spurious line code
    property p_spur;
        s_ack_rd ##0 !PRDATA[`IPR_ACK_VALID_BIT] |-> PRDATA[3:0] == `IPR_SPURIOUS_IRQ;
    endproperty
    // The cascade input is never handed out as a line number
    property p_no_cascade;
        s_ack_rd ##0 PRDATA[`IPR_ACK_VALID_BIT] |-> PRDATA[3:0] != 4'h2 && PRDATA[7:4] == 4'h0;
    endproperty
    property p_rdata_hold;  !(PSEL && PENABLE) |=> $stable(PRDATA); endproperty
    // Event line only drops after a bus access cleared or masked it
    property p_evt_fall;    $fell(EVT_IRQ) |-> $past(PREADY) || $past(PREADY, 2); endproperty

    a_rdy_pulse:   assert property (p_rdy_pulse) else $error("ready longer than one cycle");
    a_wait_state:  assert property (p_wait_state) else $error("wrong wait state count");
    a_err_rdy:     assert property (p_err_rdy) else $error("error without ready");
    a_unmapped:    assert property (p_unmapped) else $error("unmapped access not refused");
    a_mapped:      assert property (p_mapped) else $error("mapped access refused");
    a_spur:        assert property (p_spur) else $error("bad spurious code");
    a_no_cascade:  assert property (p_no_cascade) else $error("cascade line acknowledged");
    a_rdata_hold:  assert property (p_rdata_hold) else $error("read data moved while idle");
    a_evt_fall:    assert property (p_evt_fall) else $error("event line fell on its own");
endmodule

bind ipr_top ipr_checker #(.PRESCALE(PRESCALE)) u_ipr_checker (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .IRQ_IN(IRQ_IN), .PCI_INT_N(PCI_INT_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .INT_OUT(INT_OUT), .EVT_IRQ(EVT_IRQ));

// ---- test/ipr_periph.sv ----
// Model of the requesting peripherals and PCI devices on the far side.
// Assumes the bench gives active-high requests and the current sensing setup.
`timescale 1ns/10ps
module ipr_periph (
    input  logic        clk,
    input  logic [15:0] line_req,   // Request per ISA line, active high
    input  logic [3:0]  pci_req,    // Request per PCI line, active high
    input  logic [15:0] level_sel,  // Lines set to level sensing
    output logic [15:0] irq_pins,
    output logic [3:0]  pci_int_n
);
    initial begin
        irq_pins = 16'h0100;
        pci_int_n = 4'hf;
    end
    // pin polarity: level lines and line 8 request low
    always @(posedge clk) begin
        pci_int_n <= ~pci_req;
        irq_pins <= line_req ^ (level_sel | 16'h0100);
    end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the interrupt router: APB master plus peripheral model.
// Assumes the checker is bound to the top and a short timer prescale.
`timescale 1ns/10ps
`include "ipr_defines.vh"
module tb;
    localparam int PRE = 2;           // Small prescale keeps timer ticks short
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, route;
    logic        er;
    logic [15:0] line_req = 16'h0, level_sel = 16'h0, pend, irq_pins;
    logic [3:0]  pci_req = 4'h0, pci_int_n, tgt;
    wire         pready, pslverr, int_out, evt_irq;
    wire  [31:0] prdata;
    int          err_total = 0, cmp_count = 0;
    int ok_tbl [12] = '{1, 3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
    logic [7:0]  ra [5] = '{`IPR_OFF_ELS, `IPR_OFF_MASK, `IPR_OFF_ROUTE, `IPR_OFF_TIMER,
                            `IPR_OFF_EVT_MASK};
    logic [31:0] rv [5] = '{32'h0, 32'hffff, 32'h80808080, 32'hffff, 32'h0};

    initial forever #2.5 mclk = ~mclk;

    ipr_top #(.PRESCALE(PRE)) u_ipr_top (
        .MCLK(mclk), .SYS_RST(sys_rst), .IRQ_IN(irq_pins), .PCI_INT_N(pci_int_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .INT_OUT(int_out),
        .EVT_IRQ(evt_irq));
    ipr_periph u_ipr_periph (.clk(mclk), .line_req(line_req), .pci_req(pci_req),
        .level_sel(level_sel), .irq_pins(irq_pins), .pci_int_n(pci_int_n));

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; entered just after a clock edge, leaves one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask

    // Bounded wait for the cascade or event output to reach a level
    task automatic wait_for(input logic evt, input logic v);
        int n;
        n = 0;
        while (((evt ? evt_irq : int_out) !== v) && n < 40) begin
            @(posedge mclk);
            n++;
        end
        chk({31'h0, evt ? evt_irq : int_out}, {31'h0, v});
        if ((evt ? evt_irq : int_out) !== v) close_out();
    endtask

    // Expected acknowledge word for a set of pending lines
    function automatic logic [31:0] exp_ack(input logic [15:0] p);
        int ord [15] = '{0, 1, 8, 9, 10, 11, 12, 13, 14, 15, 3, 4, 5, 6, 7};
        for (int i = 0; i < 15; i++)
            if (p[ord[i]]) return 32'h100 | 32'(ord[i]);
        return 32'h7;
    endfunction

    initial begin
        void'($urandom(32'h1a3a));
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, rv[i]);
        end
        apb(1'b1, `IPR_OFF_ELS, 32'hffff);
        apb(1'b0, `IPR_OFF_ELS, 32'h0);
        chk(rd, 32'hdef8);
        // level sensing for every line whose sensing may be changed; line 1 may carry PCI requests but stays edge
        level_sel <= 16'hdef8;
        apb(1'b1, `IPR_OFF_ISR, 32'hffff);
        apb(1'b0, `IPR_OFF_ISR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `IPR_OFF_MASK, 32'h0001);
        // Priority rounds: first with every pin line at once, then random sets
        for (int r = 0; r < 4; r++) begin
            pend = (r == 0) ? 16'hfffa : 16'($urandom) & 16'hfffa;
            if (pend == 16'h0) pend = 16'h0008;
            line_req <= pend;
            wait_for(1'b0, 1'b1);
            while (pend != 16'h0) begin
                apb(1'b0, `IPR_OFF_ACK, 32'h0);
                chk(rd, exp_ack(pend));
                pend[rd[3:0]] = 1'b0;
                line_req <= pend;
                repeat (6) @(posedge mclk);
                chk({31'h0, int_out}, 32'h0);
                apb(1'b1, `IPR_OFF_EOI, (rd[3:0] >= 4'h8) ? 32'h3 : 32'h1);
                if (pend != 16'h0) wait_for(1'b0, 1'b1);
            end
            apb(1'b0, `IPR_OFF_ACK, 32'h0);
            chk(rd, 32'h7);
        end
        // PCI steering; the last pass aims at a reserved line
        for (int n = 0; n < 5; n++) begin
            tgt = (n == 4) ? 4'hd : 4'(ok_tbl[$urandom % 12]);
            route = 32'h80808080;
            route[8 * (n % 4) +: 8] = {4'h0, tgt};
            // route set up before the source is used
            apb(1'b1, `IPR_OFF_ROUTE, route);
            pci_req <= 4'(1 << (n % 4));
            if (n == 4) begin
                repeat (10) @(posedge mclk);
                chk({31'h0, int_out}, 32'h0);
            end else
                wait_for(1'b0, 1'b1);
            apb(1'b0, `IPR_OFF_ACK, 32'h0);
            chk(rd, (n == 4) ? 32'h7 : (32'h100 | 32'(tgt)));
            pci_req <= 4'h0;
            repeat (6) @(posedge mclk);
            apb(1'b1, `IPR_OFF_EOI, (tgt >= 4'h8) ? 32'h3 : 32'h1);
        end
        // Internal timer on line 0
        apb(1'b1, `IPR_OFF_TIMER, 32'h1);
        apb(1'b1, `IPR_OFF_MASK, 32'hfffe);
        wait_for(1'b0, 1'b1);
        apb(1'b0, `IPR_OFF_ACK, 32'h0);
        chk(rd, 32'h100);
        apb(1'b1, `IPR_OFF_MASK, 32'hffff);
        apb(1'b1, `IPR_OFF_EOI, 32'h1);
        // Spurious acknowledge raises the event line only while enabled
        apb(1'b1, `IPR_OFF_EVT_MASK, 32'h2);
        apb(1'b0, `IPR_OFF_ACK, 32'h0);
        wait_for(1'b1, 1'b1);
        apb(1'b0, `IPR_OFF_EVT_STAT, 32'h0);
        chk(rd & 32'h2, 32'h2);
        repeat (3) @(posedge mclk);
        chk({31'h0, evt_irq}, 32'h0);
        apb(1'b1, `IPR_OFF_EVT_MASK, 32'h0);
        apb(1'b0, `IPR_OFF_ACK, 32'h0);
        repeat (4) @(posedge mclk);
        chk({31'h0, evt_irq}, 32'h0);
        close_out();
    end
endmodule
